// *** core/rwc_pkg.sv ***
// constants for the reset and watchdog control block
//
// Summary of operation
// - Power-on, watchdog and USB bus reset sources
// - Reset restores defaults, clears address, disables interrupts
// - Both stack pointers load 0x00 on reset
// - Reset cause recorded in status bits 4-6
// - Fetch starts at 0x0000 after hardware reset
// - Reset entry pushes nothing onto program stack
// - Power-on reset sets power_on_flag bit 4
// - Power-on floats ports and samples strap bit
// - Strap high, bus idle: suspend until wake
// - Wake with strap high: 128 us delay
// - Strap low at power-on: 96 ms delay
// - Delay chosen from strap and power_on_flag
// - Watchdog MSB rising edge causes reset, bit 6
// - Watchdog advances on timer bit 11 tick
// - Any write to 0x26 clears watchdog
// - Firmware clears watchdog within 4.096 ms
// - Watchdog reset held 2.048 ms, then run
// - Transmitter off until address MSB set
// - Free-running timer 1 MHz, low byte 0x24
// - High nibble at 0x25 latched on low read
package rwc_pkg;
   // ==========================================
   // i/o addresses
   localparam logic [7:0] ADDR_USB_ADDR   = 8'h10;
   localparam logic [7:0] ADDR_TMR_LOW    = 8'h24;
   localparam logic [7:0] ADDR_TMR_HIGH   = 8'h25;
   localparam logic [7:0] ADDR_WDT_CLEAR  = 8'h26;
   localparam logic [7:0] ADDR_STATUS     = 8'hFF;
   // ==========================================
   // field positions and reset values
   localparam int         BIT_POR         = 4;
   localparam int         BIT_USBRST      = 5;
   localparam int         BIT_WDR         = 6;
   localparam int         BIT_TX_EN       = 7;
   localparam int         TMR_W           = 12;
   localparam int         TMR_TICK_BIT    = 11;
   localparam int         WDT_W           = 2;
   localparam logic [7:0] BYTE_ZERO       = 8'h00;
   localparam logic [7:0] STACK_RESET     = 8'h00;
   localparam logic [13:0] RESET_VECTOR   = 14'h0000;
   // ==========================================
   // timing
   localparam int         CLK_HZ          = 125_000_000;
   localparam int         TMR_HZ          = 1_000_000;
   localparam int         PRESCALE        = CLK_HZ / TMR_HZ;
   localparam int         DLY_SHORT_US    = 128;
   localparam int         DLY_LONG_MS     = 96;
   localparam int         WDT_HOLD_US     = 2048;
   localparam int         DLY_LONG_US     = DLY_LONG_MS * 1000;
   // ==========================================
   // sequencer states
   typedef enum logic [4:0] {
      ST_SAMPLE  = 5'b00001,
      ST_SUSPEND = 5'b00010,
      ST_DELAY   = 5'b00100,
      ST_RUN     = 5'b01000,
      ST_WDHOLD  = 5'b10000
   } rwc_state_e;
endpackage

// *** core/rwc_reset_watchdog.sv ***
// reset sequencer, watchdog, free-running timer and status register
`timescale 1ns/1ps
module rwc_reset_watchdog #(
   parameter int DLY_SHORT_US = rwc_pkg::DLY_SHORT_US,
   parameter int DLY_LONG_US  = rwc_pkg::DLY_LONG_US,
   parameter int WDT_HOLD_US  = rwc_pkg::WDT_HOLD_US,
   parameter int PRESCALE     = rwc_pkg::PRESCALE
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [7:0]  io_addr_i,
   input  wire logic        io_wr_i,
   input  wire logic        io_rd_i,
   input  wire logic [7:0]  io_wdata_i,
   output logic      [7:0]  io_rdata_o,
   input  wire logic        strap_p3_7_i,
   input  wire logic        usb_dm_i,
   input  wire logic        usb_dp_i,
   input  wire logic        usb_bus_reset_i,
   input  wire logic        psp_load_i,
   input  wire logic        dsp_load_i,
   input  wire logic [7:0]  sp_wdata_i,
   output logic      [7:0]  program_stack_pointer_o,
   output logic      [7:0]  data_stack_pointer_o,
   output logic      [7:0]  usb_device_address_o,
   output logic             usb_tx_en_o,
   output logic             cpu_rst_o,
   output logic             cpu_run_o,
   output logic      [13:0] cpu_fetch_addr_o,
   output logic             stack_push_o,
   output logic             int_disable_o,
   output logic             gpio_hiz_o,
   output logic             suspend_o
);
   localparam int DW = $clog2(DLY_LONG_US + 1);
   localparam int PW = $clog2(PRESCALE);
   localparam logic [DW-1:0] D_SHORT = DW'(DLY_SHORT_US - 1);
   localparam logic [DW-1:0] D_LONG  = DW'(DLY_LONG_US - 1);
   localparam logic [DW-1:0] D_WDT   = DW'(WDT_HOLD_US - 1);
   localparam logic [PW-1:0] P_LAST  = PW'(PRESCALE - 1);

   typedef struct packed {
      rwc_pkg::rwc_state_e           st;
      logic [PW-1:0]                 pre;
      logic [rwc_pkg::TMR_W-1:0]     tmr;
      logic [3:0]                    tmr_hi;
      logic                          tick_prev;
      logic [rwc_pkg::WDT_W-1:0]     wdt;
      logic [DW-1:0]                 dly;
      logic [7:0]                    status;
      logic [7:0]                    usb_addr;
      logic [7:0]                    program_stack_pointer;
      logic [7:0]                    dsp;
      logic [7:0]                    rdata;
      logic                          strap;
   } rwc_regs_s;

   rwc_regs_s r_reg;
   rwc_regs_s r_next;

   logic us_tick;
   logic wdt_tick;
   logic bus_idle;
   logic wake;
   logic wdt_fire;
   logic in_reset;

   // ==========================================
   // combinational next state
   always_comb begin
      r_next   = r_reg;
      us_tick  = (r_reg.pre == P_LAST);
      r_next.pre = us_tick ? '0 : r_reg.pre + 1'b1;
      // 1 MHz free-running timer
      if (us_tick) begin
         r_next.tmr = r_reg.tmr + 1'b1;
      end
      r_next.tick_prev = r_reg.tmr[rwc_pkg::TMR_TICK_BIT];
      wdt_tick = r_reg.tmr[rwc_pkg::TMR_TICK_BIT] & ~r_reg.tick_prev;
      bus_idle = usb_dm_i & ~usb_dp_i;
      wake     = usb_bus_reset_i | ~usb_dm_i;
      in_reset = (r_reg.st != rwc_pkg::ST_RUN);
      wdt_fire = 1'b0;
      r_next.rdata = rwc_pkg::BYTE_ZERO;

      // watchdog counter
      if (in_reset) begin
         r_next.wdt = '0;
      end else if (io_wr_i && io_addr_i == rwc_pkg::ADDR_WDT_CLEAR) begin
         r_next.wdt = '0;
      end else if (wdt_tick) begin
         r_next.wdt = r_reg.wdt + 1'b1;
         // msb going low to high
         wdt_fire = ~r_reg.wdt[1] & r_reg.wdt[0];
      end

      // processor i/o port
      if (!in_reset && io_wr_i) begin
         if (io_addr_i == rwc_pkg::ADDR_USB_ADDR) begin
            r_next.usb_addr = io_wdata_i;
         end else if (io_addr_i == rwc_pkg::ADDR_STATUS) begin
            r_next.status = io_wdata_i;
         end
      end
      if (!in_reset && io_rd_i) begin
         if (io_addr_i == rwc_pkg::ADDR_USB_ADDR) begin
            r_next.rdata = r_reg.usb_addr;
         end else if (io_addr_i == rwc_pkg::ADDR_TMR_LOW) begin
            r_next.rdata  = r_reg.tmr[7:0];
            r_next.tmr_hi = r_reg.tmr[11:8];
         end else if (io_addr_i == rwc_pkg::ADDR_TMR_HIGH) begin
            r_next.rdata = {4'h0, r_reg.tmr_hi};
         end else if (io_addr_i == rwc_pkg::ADDR_STATUS) begin
            r_next.rdata = r_reg.status;
         end
      end

      // stack pointer loads by firmware
      if (!in_reset && psp_load_i) begin
         r_next.program_stack_pointer = sp_wdata_i;
      end
      if (!in_reset && dsp_load_i) begin
         r_next.dsp = sp_wdata_i;
      end

      // usb bus reset: soft reset, no sequencer action
      if (usb_bus_reset_i && !in_reset) begin
         r_next.status[rwc_pkg::BIT_USBRST] = 1'b1;
         r_next.usb_addr = rwc_pkg::BYTE_ZERO;
      end

      // sequencer
      case (r_reg.st)
         rwc_pkg::ST_SAMPLE: begin
            r_next.strap = strap_p3_7_i;
            if (strap_p3_7_i && bus_idle) begin
               r_next.st = rwc_pkg::ST_SUSPEND;
            end else begin
               r_next.st = rwc_pkg::ST_DELAY;
               // strap high selects short, else power_on_flag picks long
               if (strap_p3_7_i || !r_reg.status[rwc_pkg::BIT_POR]) begin
                  r_next.dly = D_SHORT;
               end else begin
                  r_next.dly = D_LONG;
               end
            end
         end
         rwc_pkg::ST_SUSPEND: begin
            if (wake) begin
               r_next.st = rwc_pkg::ST_DELAY;
               if (strap_p3_7_i || !r_reg.status[rwc_pkg::BIT_POR]) begin
                  r_next.dly = D_SHORT;
               end else begin
                  r_next.dly = D_LONG;
               end
            end
         end
         rwc_pkg::ST_DELAY: begin
            if (us_tick) begin
               if (r_reg.dly == '0) begin
                  r_next.st = rwc_pkg::ST_RUN;
               end else begin
                  r_next.dly = r_reg.dly - 1'b1;
               end
            end
         end
         rwc_pkg::ST_WDHOLD: begin
            if (us_tick) begin
               if (r_reg.dly == '0) begin
                  r_next.st = rwc_pkg::ST_RUN;
               end else begin
                  r_next.dly = r_reg.dly - 1'b1;
               end
            end
         end
         default: begin
            if (wdt_fire) begin
               r_next.st  = rwc_pkg::ST_WDHOLD;
               r_next.dly = D_WDT;
            end
         end
      endcase

      // any hardware reset period reinitialises owned registers
      if (in_reset || wdt_fire) begin
         r_next.usb_addr = rwc_pkg::BYTE_ZERO;
         r_next.program_stack_pointer      = rwc_pkg::STACK_RESET;
         r_next.dsp      = rwc_pkg::STACK_RESET;
      end
      if (wdt_fire) begin
         r_next.status[rwc_pkg::BIT_WDR] = 1'b1;
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r_reg          <= '0;
         r_reg.st       <= rwc_pkg::ST_SAMPLE;
         // power-on records its own cause
         r_reg.status   <= rwc_pkg::BYTE_ZERO;
         r_reg.status[rwc_pkg::BIT_POR] <= 1'b1;
         r_reg.program_stack_pointer      <= rwc_pkg::STACK_RESET;
         r_reg.dsp      <= rwc_pkg::STACK_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   // ==========================================
   // outputs
   assign io_rdata_o              = r_reg.rdata;
   assign program_stack_pointer_o = r_reg.program_stack_pointer;
   assign data_stack_pointer_o    = r_reg.dsp;
   assign usb_device_address_o    = r_reg.usb_addr;
   assign usb_tx_en_o             = r_reg.usb_addr[rwc_pkg::BIT_TX_EN];
   assign cpu_rst_o               = (r_reg.st != rwc_pkg::ST_RUN);
   assign cpu_run_o               = (r_reg.st == rwc_pkg::ST_RUN);
   assign cpu_fetch_addr_o        = rwc_pkg::RESET_VECTOR;
   // reset entry never pushes pc or flags
   assign stack_push_o            = 1'b0;
   assign int_disable_o           = (r_reg.st != rwc_pkg::ST_RUN);
   assign gpio_hiz_o              = r_reg.st[0] | r_reg.st[1] | (r_reg.st[2] & ~r_reg.status[rwc_pkg::BIT_WDR]);
   assign suspend_o               = (r_reg.st == rwc_pkg::ST_SUSPEND);
endmodule

// *** sim/rwc_chk_sva.sv ***
// checker for the reset and watchdog control block
`timescale 1ns/1ps
module rwc_chk (
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic [7:0]  program_stack_pointer_o,
   input wire logic [7:0]  data_stack_pointer_o,
   input wire logic [7:0]  usb_device_address_o,
   input wire logic        usb_tx_en_o,
   input wire logic        cpu_rst_o,
   input wire logic [13:0] cpu_fetch_addr_o,
   input wire logic        stack_push_o,
   input wire logic        int_disable_o,
   input wire logic        gpio_hiz_o,
   input wire logic        suspend_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_no_push: assert property (!stack_push_o) else $error("stack push seen");
   a_fetch_zero: assert property (cpu_fetch_addr_o == 14'h0000) else $error("fetch not zero");
   a_int_off: assert property (cpu_rst_o |-> int_disable_o) else $error("irq on in reset");
   a_addr_clear: assert property (cpu_rst_o |-> usb_device_address_o == 8'h00) else $error("addr kept");
   a_stack_clear: assert property (cpu_rst_o |->
      (program_stack_pointer_o | data_stack_pointer_o) == 8'h00) else $error("stack kept");
   a_tx_msb: assert property (usb_tx_en_o == usb_device_address_o[7]) else $error("tx enable wrong");
   a_susp_stop: assert property (suspend_o |-> cpu_rst_o && gpio_hiz_o) else $error("runs in suspend");
   a_wd_hold: assert property ($rose(cpu_rst_o) |-> cpu_rst_o [*8]) else $error("hold too short");
   a_wake_hold: assert property ($fell(suspend_o) |-> cpu_rst_o [*8]) else $error("no wake delay");
endmodule
bind rwc_reset_watchdog rwc_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .program_stack_pointer_o(program_stack_pointer_o), .data_stack_pointer_o(data_stack_pointer_o),
   .usb_device_address_o(usb_device_address_o), .usb_tx_en_o(usb_tx_en_o), .cpu_rst_o(cpu_rst_o),
   .cpu_fetch_addr_o(cpu_fetch_addr_o), .stack_push_o(stack_push_o), .int_disable_o(int_disable_o),
   .gpio_hiz_o(gpio_hiz_o), .suspend_o(suspend_o));

// *** sim/rwc_usb_line.sv ***
// upstream bus line model: 0 idle, 1 k resume, 2 se0, 3 bus reset
`timescale 1ns/1ps
module rwc_usb_line (
   input  wire logic [1:0] line_cmd_i,
   output logic            usb_dm_o,
   output logic            usb_dp_o,
   output logic            bus_reset_o
);
   assign usb_dm_o    = (line_cmd_i == 2'h0);
   assign usb_dp_o    = (line_cmd_i == 2'h1);
   assign bus_reset_o = (line_cmd_i == 2'h3);
endmodule

// *** sim/rwc_reset_watchdog_tb.sv ***
// self-checking bench for the reset and watchdog control block
`timescale 1ns/1ps
module rwc_reset_watchdog_tb;
   logic        clk_i = 0, rst = 1, wr = 0, rd = 0, strap = 0, pl = 0, dl = 0;
   logic [7:0]  a = 0, wd = 0, spd = 0, rdata, r, h, program_stack_pointer, dsp, ua;
   logic [1:0]  cmd = 0;
   logic        dm, dp, br, tx, crst, crun, hiz, susp;
   int          err_count = 0, tests_run = 0, n;
   // write flag, address, data, expected read
   logic [24:0] rows [7] = '{25'h0FF0010, 25'h1FF0000, 25'h0FF0000, 25'h1108500, 25'h0100085, 25'h026A500,
                             25'h0300000};
   rwc_usb_line usb_u (.line_cmd_i(cmd), .usb_dm_o(dm), .usb_dp_o(dp), .bus_reset_o(br));
   rwc_reset_watchdog #(.DLY_SHORT_US(8), .DLY_LONG_US(200), .WDT_HOLD_US(16), .PRESCALE(4)) dut_u (
      .clk_i(clk_i), .sys_rst_i(rst), .io_addr_i(a), .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wd),
      .io_rdata_o(rdata), .strap_p3_7_i(strap), .usb_dm_i(dm), .usb_dp_i(dp), .usb_bus_reset_i(br),
      .psp_load_i(pl), .dsp_load_i(dl), .sp_wdata_i(spd), .program_stack_pointer_o(program_stack_pointer),
      .data_stack_pointer_o(dsp), .usb_device_address_o(ua), .usb_tx_en_o(tx), .cpu_rst_o(crst),
      .cpu_run_o(crun), .cpu_fetch_addr_o(), .stack_push_o(), .int_disable_o(), .gpio_hiz_o(hiz),
      .suspend_o(susp));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   // strobe set at a falling edge, taken at the next rising edge, data read one cycle on
   task automatic io(input logic w, input logic [7:0] ad, input logic [7:0] d);
      @(negedge clk_i);
      a = ad;
      wr = w;
      rd = !w;
      wd = d;
      @(negedge clk_i);
      wr = 0;
      rd = 0;
      r = rdata;
   endtask
   task automatic wt(input logic want_run);
      n = 0;
      while ((want_run ? crun : crst) !== 1'b1 && n < 30000) begin
         @(negedge clk_i);
         n++;
      end
   endtask
   task automatic por(input logic s);
      rst = 1;
      strap = s;
      repeat (10) @(negedge clk_i);
      rst = 0;
      repeat (8) @(negedge clk_i);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      #(8 * 95000);
      err_count++;
      test_done();
   end
   initial begin
      por(0);
      chk({crst, hiz, susp}, 3'b110, "por hold");
      wt(1);
      chk(n inside {[780:815]}, 1, "long delay");
      $display("test startup done");
      foreach (rows[i]) begin
         io(rows[i][24], rows[i][23:16], rows[i][15:8]);
         if (!rows[i][24]) chk(r, rows[i][7:0], "register read");
      end
      chk(tx, 1, "tx enable");
      @(negedge clk_i);
      spd = 8'hE7;
      pl = 1;
      dl = 1;
      @(negedge clk_i);
      pl = 0;
      dl = 0;
      chk({program_stack_pointer, dsp}, 16'hE7E7, "stack load");
      $display("test registers done");
      io(0, 8'h24, 8'h00);
      h = r;
      repeat (398) @(negedge clk_i);
      io(0, 8'h24, 8'h00);
      chk(8'(r - h), 8'h64, "timer rate");
      io(0, 8'h25, 8'h00);
      h = r;
      repeat (4400) @(negedge clk_i);
      io(0, 8'h25, 8'h00);
      chk(r, h, "high nibble latched");
      $display("test timer done");
      cmd = 2'h3;
      repeat (4) @(negedge clk_i);
      cmd = 2'h0;
      io(0, 8'hFF, 8'h00);
      chk({r, ua, 7'h00, crun}, 24'h200001, "bus reset");
      io(1, 8'h10, 8'h85);
      repeat (3) begin
         io(1, 8'h26, 8'h00);
         repeat (12000) @(negedge clk_i);
         chk(crun, 1, "watchdog cleared");
      end
      wt(0);
      chk(n inside {[4380:20780]}, 1, "watchdog fire");
      wt(1);
      chk(n inside {[60:70]}, 1, "watchdog hold");
      io(0, 8'hFF, 8'h00);
      chk({r, ua, program_stack_pointer}, 24'h600000, "after watchdog");
      chk(tx, 0, "tx off");
      $display("test watchdog done");
      por(1);
      chk({susp, hiz, crst}, 3'b111, "suspend");
      repeat (200) @(negedge clk_i);
      chk(susp, 1, "still suspended");
      cmd = 2'h1;
      wt(1);
      chk(n inside {[28:44]}, 1, "short delay");
      io(0, 8'hFF, 8'h00);
      chk(r, 8'h10, "por status");
      $display("test suspend done");
      test_done();
   end
endmodule
